// file: pkg/rrsa_consts.svh
`ifndef RRSA_CONSTS_SVH
`define RRSA_CONSTS_SVH

// Register byte addresses
`define RRSA_ADDR_ACC 8'h00
`define RRSA_ADDR_FLAGS 8'h04
`define RRSA_ADDR_CMD 8'h08
// Memory window 0x40..0x7c, one byte per word
`define RRSA_MEM_SEL_HI 7
`define RRSA_MEM_SEL_LO 6
`define RRSA_MEM_SEL 2'b01
`define RRSA_MEM_IDX_LO 2

// Command word fields
`define RRSA_CMD_OP_HI 2
`define RRSA_CMD_OP_LO 0
`define RRSA_CMD_IDX_LO 8

// Reset values
`define RRSA_ACC_RST 8'h00
`define RRSA_FLAGS_RST 6'h00
`define RRSA_MEM_RST 8'h00

// Bus responses
`define RRSA_RESP_OKAY 2'b00
`define RRSA_RESP_SLVERR 2'b10

`endif

// file: pkg/rrsa_pkg.sv
package rrsa_pkg;

  typedef enum logic [2:0] {
    OP_IDLE,
    OP_ROTATE_RIGHT_MEM,
    OP_ROTATE_RIGHT_TO_ACC,
    OP_ROTATE_RIGHT_THRU_CARRY_MEM,
    OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC,
    OP_SUBTRACT_BORROW_TO_ACC,
    OP_SUBTRACT_BORROW_TO_MEM
  } rrsa_op_type;

  // Bit 0 is carry, bit 5 the chained zero flag
  typedef struct packed {
    logic chained_zero_flag;
    logic signed_result_flag;
    logic signed_wrap_flag;
    logic zero;
    logic half_borrow_flag;
    logic carry;
  } rrsa_flags_type;

endpackage : rrsa_pkg

// file: hw/rrsa_alu.sv
`timescale 1ns/1ps
module rrsa_alu
  import rrsa_pkg::*;
(
  input wire rrsa_op_type op,
  input wire logic [7:0] acc,
  input wire logic [7:0] mem,
  input wire rrsa_flags_type flags,
  output logic [7:0] result,
  output rrsa_flags_type flags_new,
  output logic acc_we,
  output logic mem_we
);

  wire logic [8:0] diff = {1'b0, acc} - {1'b0, mem} - {8'h00, ~flags.carry};
  wire logic [4:0] low_diff = {1'b0, acc[3:0]} - {1'b0, mem[3:0]} - {4'h0, ~flags.carry};
  wire logic [7:0] rot_plain = {mem[0], mem[7:1]};
  wire logic [7:0] rot_carry = {flags.carry, mem[7:1]};
  wire logic wrap = (acc[7] ^ mem[7]) & (acc[7] ^ diff[7]);
  wire logic is_zero = (diff[7:0] == 8'h00);

  always_comb begin
    result = mem;
    flags_new = flags;
    acc_we = 1'b0;
    mem_we = 1'b0;
    case (op)
      OP_ROTATE_RIGHT_MEM: begin
        result = rot_plain; // [RULE_01]
        mem_we = 1'b1;
      end
      OP_ROTATE_RIGHT_TO_ACC: begin
        result = rot_plain; // [RULE_02]
        acc_we = 1'b1;
      end
      OP_ROTATE_RIGHT_THRU_CARRY_MEM: begin
        result = rot_carry; // [RULE_03]
        flags_new.carry = mem[0];
        mem_we = 1'b1;
      end
      OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC: begin
        result = rot_carry; // [RULE_04]
        flags_new.carry = mem[0];
        acc_we = 1'b1;
      end
      OP_SUBTRACT_BORROW_TO_ACC, OP_SUBTRACT_BORROW_TO_MEM: begin
        result = diff[7:0]; // [RULE_05] [RULE_06]
        acc_we = (op == OP_SUBTRACT_BORROW_TO_ACC);
        mem_we = (op == OP_SUBTRACT_BORROW_TO_MEM);
        flags_new.carry = ~diff[8]; // [RULE_07]
        flags_new.zero = is_zero; // [RULE_08] [RULE_09]
        flags_new.half_borrow_flag = low_diff[4]; // [RULE_09]
        flags_new.signed_wrap_flag = wrap; // [RULE_09]
        flags_new.signed_result_flag = diff[7] ^ wrap; // [RULE_08]
        flags_new.chained_zero_flag = is_zero & flags.chained_zero_flag; // [RULE_08]
      end
      default: begin
        result = mem;
      end
    endcase
  end

endmodule : rrsa_alu

// file: hw/rrsa_top.sv
// How it works
// RULE_01 - Rotate memory right, bit0 to bit7, flags kept
// RULE_02 - Same rotation into accumulator, memory and flags kept
// RULE_03 - Rotate memory through carry, only carry changes
// RULE_04 - Rotate through carry into accumulator, memory kept
// RULE_05 - Accumulator minus memory minus not-carry into accumulator
// RULE_06 - Same difference into memory, accumulator kept
// RULE_07 - Carry cleared on borrow, set otherwise
// RULE_08 - Subtraction updates six status flags
// RULE_09 - Zero, low-nibble borrow and signed overflow equations
`timescale 1ns/1ps
`include "rrsa_consts.svh"
module rrsa_top
  import rrsa_pkg::*;
#(
  parameter int MEM_DEPTH = 16,
  parameter int IDX_W = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  logic [7:0] acc_q;
  rrsa_flags_type flags_q;
  logic [7:0] mem_q [MEM_DEPTH];
  logic [IDX_W-1:0] last_idx_q;
  rrsa_op_type last_op_q;
  logic [7:0] wr_addr_q;
  logic [31:0] wr_data_q;
  logic [3:0] wr_strb_q;
  logic aw_have_q;
  logic w_have_q;

  // Channel handshakes
  wire logic aw_take = s_axi_awvalid & s_axi_awready;
  wire logic w_take = s_axi_wvalid & s_axi_wready;
  wire logic ar_take = s_axi_arvalid & s_axi_arready;
  wire logic wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire logic lane0 = wr_strb_q[0];

  // Write decode
  wire logic wsel_acc = (wr_addr_q == `RRSA_ADDR_ACC);
  wire logic wsel_flags = (wr_addr_q == `RRSA_ADDR_FLAGS);
  wire logic wsel_cmd = (wr_addr_q == `RRSA_ADDR_CMD);
  wire logic wsel_mem = (wr_addr_q[`RRSA_MEM_SEL_HI:`RRSA_MEM_SEL_LO] == `RRSA_MEM_SEL);
  wire logic wr_hit = wsel_acc | wsel_flags | wsel_cmd | wsel_mem;
  wire logic [IDX_W-1:0] wr_idx = wr_addr_q[`RRSA_MEM_IDX_LO +: IDX_W];

  // Command decode
  wire logic exec_go = wr_fire & wsel_cmd & lane0;
  wire rrsa_op_type exec_op = rrsa_op_type'(wr_data_q[`RRSA_CMD_OP_HI:`RRSA_CMD_OP_LO]);
  wire logic [IDX_W-1:0] exec_idx = wr_data_q[`RRSA_CMD_IDX_LO +: IDX_W];
  wire logic [7:0] mem_rd = mem_q[exec_idx];

  logic [7:0] alu_result;
  rrsa_flags_type alu_flags;
  logic alu_acc_we;
  logic alu_mem_we;

  rrsa_alu u_alu (
    .op(exec_op),
    .acc(acc_q),
    .mem(mem_rd),
    .flags(flags_q),
    .result(alu_result),
    .flags_new(alu_flags),
    .acc_we(alu_acc_we),
    .mem_we(alu_mem_we)
  );

  // Read decode
  wire logic [IDX_W-1:0] rd_idx = s_axi_araddr[`RRSA_MEM_IDX_LO +: IDX_W];
  wire logic rsel_acc = (s_axi_araddr == `RRSA_ADDR_ACC);
  wire logic rsel_flags = (s_axi_araddr == `RRSA_ADDR_FLAGS);
  wire logic rsel_cmd = (s_axi_araddr == `RRSA_ADDR_CMD);
  wire logic rsel_mem = (s_axi_araddr[`RRSA_MEM_SEL_HI:`RRSA_MEM_SEL_LO] == `RRSA_MEM_SEL);
  wire logic rd_hit = rsel_acc | rsel_flags | rsel_cmd | rsel_mem;
  wire logic [31:0] rd_word =
    rsel_acc ? {24'h000000, acc_q} :
    rsel_flags ? {26'h0000000, flags_q} :
    rsel_cmd ? {{(24-IDX_W){1'b0}}, last_idx_q, 5'h00, last_op_q} :
    rsel_mem ? {24'h000000, mem_q[rd_idx]} : 32'h00000000;

  // Write channel
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 32'h00000000;
      wr_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RRSA_RESP_OKAY;
    end else begin
      if (aw_take) begin
        s_axi_awready <= 1'b0;
        aw_have_q <= 1'b1;
        wr_addr_q <= s_axi_awaddr;
      end else if (!aw_have_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (w_take) begin
        s_axi_wready <= 1'b0;
        w_have_q <= 1'b1;
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
      end else if (!w_have_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RRSA_RESP_OKAY : `RRSA_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RRSA_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `RRSA_RESP_OKAY : `RRSA_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Accumulator, flags and last command
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      acc_q <= `RRSA_ACC_RST;
      flags_q <= `RRSA_FLAGS_RST;
      last_op_q <= OP_IDLE;
      last_idx_q <= '0;
    end else if (exec_go) begin
      last_op_q <= exec_op;
      last_idx_q <= exec_idx;
      flags_q <= alu_flags; // [RULE_07] [RULE_08]
      if (alu_acc_we) begin
        acc_q <= alu_result; // [RULE_02] [RULE_04] [RULE_05]
      end
    end else if (wr_fire && lane0 && wsel_acc) begin
      acc_q <= wr_data_q[7:0];
    end else if (wr_fire && lane0 && wsel_flags) begin
      flags_q <= rrsa_flags_type'(wr_data_q[5:0]);
    end
  end

  // Data memory, one byte per entry
  genvar gi;
  generate
    for (gi = 0; gi < MEM_DEPTH; gi++) begin : g_mem
      wire logic sw_we = wr_fire & lane0 & wsel_mem & (wr_idx == IDX_W'(gi));
      wire logic op_we = exec_go & alu_mem_we & (exec_idx == IDX_W'(gi));
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          mem_q[gi] <= `RRSA_MEM_RST;
        end else if (op_we) begin
          mem_q[gi] <= alu_result; // [RULE_01] [RULE_03] [RULE_06]
        end else if (sw_we) begin
          mem_q[gi] <= wr_data_q[7:0];
        end
      end
    end
  endgenerate

  // Checks
  wire logic [8:0] sub_need = {1'b0, mem_rd} + {8'h00, ~flags_q.carry};
  wire logic no_borrow = ({1'b0, acc_q} >= sub_need);
  wire logic is_sub = (exec_op == OP_SUBTRACT_BORROW_TO_ACC) |
    (exec_op == OP_SUBTRACT_BORROW_TO_MEM);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_go(rrsa_op_type o);
    exec_go && exec_op == o;
  endsequence

  sequence s_sub_go;
    exec_go && is_sub;
  endsequence

  a_rot_mem_write: assert property (s_go(OP_ROTATE_RIGHT_MEM) |=> // [RULE_01]
    mem_q[$past(exec_idx)] == {$past(mem_rd[0]), $past(mem_rd[7:1])} &&
    flags_q == $past(flags_q) && acc_q == $past(acc_q))
    else $error("rotate right to memory wrong");
  a_rot_acc_load: assert property (s_go(OP_ROTATE_RIGHT_TO_ACC) |=> // [RULE_02]
    acc_q == {$past(mem_rd[0]), $past(mem_rd[7:1])} &&
    mem_q[$past(exec_idx)] == $past(mem_rd) && flags_q == $past(flags_q))
    else $error("rotate right to accumulator wrong");
  a_rotc_mem_ring: assert property (s_go(OP_ROTATE_RIGHT_THRU_CARRY_MEM) |=> // [RULE_03]
    mem_q[$past(exec_idx)] == {$past(flags_q.carry), $past(mem_rd[7:1])} &&
    flags_q.carry == $past(mem_rd[0]) && flags_q[5:1] == $past(flags_q[5:1]))
    else $error("rotate through carry to memory wrong");
  a_rotc_acc_ring: assert property (s_go(OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC) |=> // [RULE_04]
    acc_q == {$past(flags_q.carry), $past(mem_rd[7:1])} &&
    flags_q.carry == $past(mem_rd[0]) && mem_q[$past(exec_idx)] == $past(mem_rd))
    else $error("rotate through carry to accumulator wrong");
  a_sub_acc_diff: assert property (s_go(OP_SUBTRACT_BORROW_TO_ACC) |=> // [RULE_05]
    acc_q == 8'($past(acc_q) - $past(mem_rd) - {7'h00, ~$past(flags_q.carry)}))
    else $error("subtract to accumulator wrong");
  a_sub_mem_diff: assert property (s_go(OP_SUBTRACT_BORROW_TO_MEM) |=> // [RULE_06]
    mem_q[$past(exec_idx)] ==
    8'($past(acc_q) - $past(mem_rd) - {7'h00, ~$past(flags_q.carry)}) &&
    acc_q == $past(acc_q))
    else $error("subtract to memory wrong");
  a_sub_carry_out: assert property (s_sub_go |=> flags_q.carry == $past(no_borrow)) // [RULE_07]
    else $error("carry after subtract wrong");
  a_sub_flag_chain: assert property (s_sub_go |=> // [RULE_08]
    flags_q.chained_zero_flag == ($past(flags_q.chained_zero_flag) && flags_q.zero) &&
    flags_q.signed_result_flag == (flags_q.signed_wrap_flag ^ $past(alu_result[7])))
    else $error("secondary flags after subtract wrong");
  a_sub_flag_eqs: assert property (s_sub_go |=> // [RULE_09]
    flags_q.zero == ($past(alu_result) == 8'h00) &&
    flags_q.half_borrow_flag ==
    ($past(acc_q[3:0]) < ({1'b0, $past(mem_rd[3:0])} + {4'h0, ~$past(flags_q.carry)})) &&
    flags_q.signed_wrap_flag == (($past(acc_q[7]) != $past(mem_rd[7])) &&
    ($past(alu_result[7]) != $past(acc_q[7]))))
    else $error("primary flags after subtract wrong");

endmodule : rrsa_top

// file: bench/rrsa_seq_model.sv
`timescale 1ns/1ps
module rrsa_seq_model (
  input wire logic core_clk,
  output logic [7:0] s_axi_awaddr,
  output logic [2:0] s_axi_awprot,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic [2:0] s_axi_arprot,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  int stall = 0;
  initial begin
    {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arprot} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
  end
  // Write, aw and w released each on its own ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (pa || pw) begin
      @(posedge core_clk);
      if (pa && s_axi_awready) begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (pw && s_axi_wready) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    repeat (stall) @(posedge core_clk);
    s_axi_bready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat (stall) @(posedge core_clk);
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : rrsa_seq_model

// file: bench/testbench.sv
`timescale 1ns/1ps
`include "rrsa_consts.svh"
module testbench
  import rrsa_pkg::*;
();
  logic core_clk;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_mismatch = 0;
  int checked = 0;
  logic [31:0] lfsr_q = 32'h4b519a81;
  rrsa_top i_rrsa_top (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  rrsa_seq_model i_rrsa_seq_model (.core_clk, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction : rnd
  // Expected {acc, mem, flags} after one command
  function automatic logic [21:0] exp_op(input logic [2:0] op, input logic [7:0] a,
    input logic [7:0] m, input rrsa_flags_type f);
    logic [8:0] d;
    logic [4:0] h;
    logic [7:0] r;
    d = {1'b0, a} - {1'b0, m} - {8'h00, ~f.carry};
    h = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~f.carry};
    case (op)
      3'h1: m = {m[0], m[7:1]};
      3'h2: a = {m[0], m[7:1]};
      3'h3, 3'h4: begin
        r = {f.carry, m[7:1]};
        f.carry = m[0];
        if (op == 3'h3) m = r;
        else a = r;
      end
      3'h5, 3'h6: begin
        f.signed_wrap_flag = (a[7] != m[7]) && (d[7] != a[7]);
        f.zero = (d[7:0] == 8'h00);
        f.half_borrow_flag = h[4];
        f.carry = ~d[8];
        f.signed_result_flag = d[7] ^ f.signed_wrap_flag;
        f.chained_zero_flag = f.zero & f.chained_zero_flag;
        if (op == 3'h5) a = d[7:0];
        else m = d[7:0];
      end
      default: ;
    endcase
    return {a, m, f};
  endfunction : exp_op
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    i_rrsa_seq_model.wr(a, d, r);
    chk({30'h0, r}, {30'h0, `RRSA_RESP_OKAY});
  endtask : bw
  task automatic br(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] r;
    i_rrsa_seq_model.rd(a, v, r);
    chk(v, e);
    chk({30'h0, r}, {30'h0, `RRSA_RESP_OKAY});
  endtask : br
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  initial begin
    #5000000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    logic [31:0] v;
    logic [1:0] r;
    logic [21:0] e;
    logic [7:0] a;
    logic [7:0] m;
    logic [5:0] f;
    logic [2:0] op;
    logic [3:0] ix;
    logic [7:0] ma;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 4; i++) br(8'(i * 4) | (i == 3 ? 8'h70 : 8'h00), 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 2; i++) begin
      ma = i[0] ? 8'h80 : 8'h0c;
      i_rrsa_seq_model.wr(ma, rnd(), r);
      chk({30'h0, r}, {30'h0, `RRSA_RESP_SLVERR});
      i_rrsa_seq_model.rd(ma, v, r);
      chk(v, 32'h0);
      chk({30'h0, r}, {30'h0, `RRSA_RESP_SLVERR});
    end
    $display("test unmapped done");
    for (int i = 0; i < 240; i++) begin
      a = 8'(rnd());
      m = 8'(rnd());
      f = 6'(rnd());
      ix = 4'(rnd());
      op = i[2:0];
      if (i < 16) begin
        a = i[3] ? 8'h80 : 8'h00;
        m = 8'h00;
        f = i[3] ? 6'h20 : 6'h21;
      end
      i_rrsa_seq_model.stall = int'(rnd() % 32'h3);
      ma = `RRSA_ADDR_FLAGS + 8'h3c + {2'b00, ix, 2'b00};
      bw(`RRSA_ADDR_ACC, {24'h0, a});
      bw(`RRSA_ADDR_FLAGS, {26'h0, f});
      bw(ma, {24'h0, m});
      bw(`RRSA_ADDR_CMD, {20'h0, ix, 5'h0, op});
      e = exp_op(op, a, m, f);
      br(`RRSA_ADDR_ACC, {24'h0, e[21:14]});
      br(ma, {24'h0, e[13:6]});
      br(`RRSA_ADDR_FLAGS, {26'h0, e[5:0]});
      br(`RRSA_ADDR_CMD, {20'h0, ix, 5'h0, op});
    end
    $display("test operations done");
    complete_run();
  end
endmodule : testbench
